//--- design/nvpcm_mirror.sv
`timescale 1ns/100ps
module nvpcm_mirror
  import nvpcm_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input nvpcm_req_s req_i,
  input wire logic [31:0] unlock_key_i,
  input wire logic nv_ack_i,
  input wire logic [7:0] nv_data_i,
  output logic nv_req_o,
  output logic [7:0] nv_addr_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic protect_on_o,
  output logic write_open_o,
  output logic load_done_o
);
  logic [NUM_MIRROR-1:0][7:0] mirror_ff, nxt_mirror;
  logic [7:0] rd_data_ff, nxt_rd_data;
  logic rd_valid_ff;
  nvpcm_ld_s ld;
  logic load_done;

  nvpcm_loader #(
    .REFRESH_CYCLES(REFRESH_CYCLES)
  ) u_loader (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .nv_ack_i(nv_ack_i),
    .nv_data_i(nv_data_i),
    .nv_req_o(nv_req_o),
    .nv_addr_o(nv_addr_o),
    .ld_o(ld),
    .done_o(load_done)
  );

  // Host address decode
  wire [3:0] dec = addr_to_idx(req_i.addr);
  wire hit = dec[3];
  wire [2:0] idx = dec[2:0];
  wire is_key = hit && (idx >= IDX_KEY0);

  // Stored key, byte 0 lowest
  wire [31:0] stored_key = {mirror_ff[5], mirror_ff[4], mirror_ff[3], mirror_ff[2]};
  wire protect_on = (mirror_ff[IDX_PEN] == PEN_ON);
  wire unlocked = (unlock_key_i == stored_key);
  wire write_open = load_done && (!protect_on || unlocked);
  // Reserved byte keeps its factory value
  wire wr_ok = req_i.wr && hit && write_open && (idx != IDX_RSVD);

  genvar g;
  generate
    for (g = 0; g < NUM_MIRROR; g++) begin : g_mirror
      wire ld_sel = ld.vld && (ld.idx == 3'(g));
      wire wr_sel = wr_ok && (idx == 3'(g));
      assign nxt_mirror[g] = ld_sel ? ld.data :
                             wr_sel ? req_i.wdata : mirror_ff[g];
    end
  endgenerate

  // Key bytes never leave through the read path
  assign nxt_rd_data = (!hit || is_key) ? 8'h00 : mirror_ff[idx];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mirror_ff[IDX_RSVD] <= RSVD_RST;
      mirror_ff[IDX_PEN] <= PEN_RST;
      for (int i = 2; i < NUM_MIRROR; i++) begin
        mirror_ff[i] <= KEY_RST;
      end
    end else begin
      mirror_ff <= nxt_mirror;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= req_i.rd;
      if (req_i.rd) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  assign rd_data_o = rd_data_ff;
  assign rd_valid_o = rd_valid_ff;
  assign protect_on_o = protect_on;
  assign write_open_o = write_open;
  assign load_done_o = load_done;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_rsvd_hold;
    !ld.vld |=> $stable(mirror_ff[IDX_RSVD]);
  endproperty
  a_rsvd_hold: assert property (p_rsvd_hold) else $error("reserved byte changed");

  property p_pen_load;
    ld.vld && (ld.idx == IDX_PEN) |=> (mirror_ff[IDX_PEN] == $past(ld.data));
  endproperty
  a_pen_load: assert property (p_pen_load) else $error("enable code not loaded");

  property p_prot_off;
    req_i.wr && (req_i.addr == ADDR_PEN) && write_open && (req_i.wdata != PEN_ON)
      ##1 !ld.vld |-> !protect_on_o;
  endproperty
  a_prot_off: assert property (p_prot_off) else $error("protection on for non-255");

  property p_prot_on;
    req_i.wr && (req_i.addr == ADDR_PEN) && write_open && (req_i.wdata == PEN_ON)
      ##1 !ld.vld |-> protect_on_o;
  endproperty
  a_prot_on: assert property (p_prot_on) else $error("protection off after 255");

  property p_deliver;
    $past(rst_i) |-> !protect_on_o && !load_done_o;
  endproperty
  a_deliver: assert property (p_deliver) else $error("enable code not 00h at reset");

  property p_key_order;
    ld.vld && (ld.idx == 3'h5) |=> (stored_key[31:24] == $past(ld.data));
  endproperty
  a_key_order: assert property (p_key_order) else $error("key byte 3 misplaced");

  property p_key_block;
    req_i.wr && is_key && protect_on && !unlocked && !ld.vld |=> $stable(stored_key);
  endproperty
  a_key_block: assert property (p_key_block) else $error("locked key written");

  property p_no_early_wr;
    !load_done && !ld.vld |=> $stable(mirror_ff[IDX_PEN]);
  endproperty
  a_no_early_wr: assert property (p_no_early_wr) else $error("write before load");

  property p_pen_write;
    req_i.wr && (req_i.addr == ADDR_PEN) && write_open && !ld.vld
      |=> (mirror_ff[IDX_PEN] == $past(req_i.wdata));
  endproperty
  a_pen_write: assert property (p_pen_write) else $error("open write lost");

  property p_pen_read;
    req_i.rd && (req_i.addr == ADDR_PEN) |=> rd_valid_o &&
      (rd_data_o == $past(mirror_ff[IDX_PEN]));
  endproperty
  a_pen_read: assert property (p_pen_read) else $error("mirror read mismatch");

  property p_key_read;
    req_i.rd && is_key |=> rd_valid_o && (rd_data_o == 8'h00);
  endproperty
  a_key_read: assert property (p_key_read) else $error("key byte readable");

  property p_key0_write;
    req_i.wr && (req_i.addr == ADDR_KEY0) && write_open && !ld.vld
      |=> (stored_key[7:0] == $past(req_i.wdata));
  endproperty
  a_key0_write: assert property (p_key0_write) else $error("key byte 0 write lost");

  property p_key3_write;
    req_i.wr && (req_i.addr == ADDR_KEY3) && write_open && !ld.vld
      |=> (stored_key[31:24] == $past(req_i.wdata));
  endproperty
  a_key3_write: assert property (p_key3_write) else $error("key byte 3 write lost");

  property p_key0_load;
    ld.vld && (ld.idx == IDX_KEY0) |=> (stored_key[7:0] == $past(ld.data));
  endproperty
  a_key0_load: assert property (p_key0_load) else $error("key byte 0 misplaced");

  property p_lock_closed;
    protect_on_o && !unlocked |-> !write_open_o;
  endproperty
  a_lock_closed: assert property (p_lock_closed) else $error("locked but writable");

  property p_open_free;
    load_done_o && !protect_on_o |-> write_open_o;
  endproperty
  a_open_free: assert property (p_open_free) else $error("unprotected but closed");

  property p_pen_block;
    req_i.wr && (req_i.addr == ADDR_PEN) && !write_open && !ld.vld
      |=> $stable(mirror_ff[IDX_PEN]);
  endproperty
  a_pen_block: assert property (p_pen_block) else $error("blocked enable write landed");

  property p_rsvd_load;
    ld.vld && (ld.idx == IDX_RSVD) |=> (mirror_ff[IDX_RSVD] == $past(ld.data));
  endproperty
  a_rsvd_load: assert property (p_rsvd_load) else $error("reserved byte not loaded");

  property p_rsvd_read;
    req_i.rd && (req_i.addr == ADDR_RSVD) |=> (rd_data_o == $past(mirror_ff[IDX_RSVD]));
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read mismatch");

  property p_void_read;
    req_i.rd && !hit |=> (rd_data_o == 8'h00);
  endproperty
  a_void_read: assert property (p_void_read) else $error("unmapped read not zero");

  property p_rd_pulse;
    !req_i.rd |=> !rd_valid_o;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe without read");

  property p_rd_hold;
    !req_i.rd |=> $stable(rd_data_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

  c_load_done: cover property ($rose(load_done_o));
  c_prot_on: cover property ($rose(protect_on_o));
  c_locked_wr: cover property (req_i.wr && is_key && !write_open);
  c_unlocked_wr: cover property (req_i.wr && is_key && protect_on && unlocked);
  c_key_wr: cover property (req_i.wr && is_key && write_open);
endmodule

//--- include/nvpcm_pkg.sv
package nvpcm_pkg;
  localparam logic [7:0] ADDR_RSVD = 8'h2B;
  localparam logic [7:0] ADDR_PEN = 8'h30;
  localparam logic [7:0] ADDR_KEY0 = 8'h31;
  localparam logic [7:0] ADDR_KEY1 = 8'h32;
  localparam logic [7:0] ADDR_KEY2 = 8'h33;
  localparam logic [7:0] ADDR_KEY3 = 8'h34;
  localparam logic [7:0] PEN_RST = 8'h00;
  localparam logic [7:0] KEY_RST = 8'h00;
  localparam logic [7:0] RSVD_RST = 8'h00;
  localparam logic [7:0] PEN_ON = 8'hFF;
  localparam int NUM_MIRROR = 6;
  localparam int IDX_W = 3;
  localparam logic [2:0] IDX_RSVD = 3'h0;
  localparam logic [2:0] IDX_PEN = 3'h1;
  localparam logic [2:0] IDX_KEY0 = 3'h2;
  localparam logic [2:0] IDX_LAST = 3'h5;
  localparam int unsigned REFRESH_MS = 66;
  localparam int unsigned CLK_HZ = 125_000_000;
  // Least time in whole cycles, REFRESH_MS times the cycles per ms, with no rounding up
  localparam int unsigned REFRESH_CYC = (REFRESH_MS * (CLK_HZ / 1000) + 0);

  typedef enum logic [1:0] {
    LD_WAIT = 2'b00,
    LD_FETCH = 2'b01,
    LD_DONE = 2'b11
  } nvpcm_ld_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nvpcm_req_s;

  typedef struct packed {
    logic vld;
    logic [2:0] idx;
    logic [7:0] data;
  } nvpcm_ld_s;

  function automatic logic [7:0] idx_to_addr(input logic [2:0] idx);
    case (idx)
      3'h0: idx_to_addr = ADDR_RSVD;
      3'h1: idx_to_addr = ADDR_PEN;
      3'h2: idx_to_addr = ADDR_KEY0;
      3'h3: idx_to_addr = ADDR_KEY1;
      3'h4: idx_to_addr = ADDR_KEY2;
      default: idx_to_addr = ADDR_KEY3;
    endcase
  endfunction

  // Returns {hit, index}
  function automatic logic [3:0] addr_to_idx(input logic [7:0] addr);
    case (addr)
      ADDR_RSVD: addr_to_idx = {1'b1, IDX_RSVD};
      ADDR_PEN: addr_to_idx = {1'b1, IDX_PEN};
      ADDR_KEY0: addr_to_idx = 4'hA;
      ADDR_KEY1: addr_to_idx = 4'hB;
      ADDR_KEY2: addr_to_idx = 4'hC;
      ADDR_KEY3: addr_to_idx = 4'hD;
      default: addr_to_idx = 4'h0;
    endcase
  endfunction
endpackage

//--- design/nvpcm_loader.sv
`timescale 1ns/100ps
module nvpcm_loader
  import nvpcm_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic nv_ack_i,
  input wire logic [7:0] nv_data_i,
  output logic nv_req_o,
  output logic [7:0] nv_addr_o,
  output nvpcm_ld_s ld_o,
  output logic done_o
);
  localparam int CNT_W = $clog2(REFRESH_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(REFRESH_CYCLES - 1);

  nvpcm_ld_e state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [2:0] idx_ff, nxt_idx;
  nvpcm_ld_s ld_ff, nxt_ld;

  wire refresh_end = (state_ff == LD_WAIT) && (cnt_ff == CNT_LAST);
  wire take = (state_ff == LD_FETCH) && nv_ack_i;

  assign nxt_cnt = (state_ff == LD_WAIT && !refresh_end) ? cnt_ff + 1'b1 : cnt_ff;
  assign nxt_idx = take ? idx_ff + 3'h1 : idx_ff;
  assign nxt_ld = '{vld: take, idx: idx_ff, data: nv_data_i};

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      LD_WAIT: if (refresh_end) nxt_state = LD_FETCH;
      LD_FETCH: if (take && idx_ff == IDX_LAST) nxt_state = LD_DONE;
      LD_DONE: nxt_state = LD_DONE;
      default: nxt_state = LD_WAIT;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_ff <= LD_WAIT;
      cnt_ff <= '0;
      idx_ff <= IDX_RSVD;
      ld_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      ld_ff <= nxt_ld;
    end
  end

  assign nv_req_o = (state_ff == LD_FETCH);
  assign nv_addr_o = idx_to_addr(idx_ff);
  assign ld_o = ld_ff;
  assign done_o = (state_ff == LD_DONE);

  property p_refresh_wait;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_ff == LD_WAIT) && (cnt_ff != CNT_LAST) |=> (state_ff == LD_WAIT);
  endproperty
  a_refresh_wait: assert property (p_refresh_wait) else $error("fetch before refresh end");

  property p_fetch_count;
    @(posedge sys_clk_i) disable iff (rst_i)
    $rose(done_o) |-> $past(nv_ack_i) && ($past(nv_addr_o) == ADDR_KEY3);
  endproperty
  a_fetch_count: assert property (p_fetch_count) else $error("load ended early");
endmodule

//--- bench/nvpcm_nv_model.sv
`timescale 1ns/100ps
module nvpcm_nv_model (
  input wire logic sys_clk_i,
  input wire logic req_i,
  input wire logic [7:0] addr_i,
  input wire logic [3:0] delay_i,
  output logic ack_o,
  output logic [7:0] data_o
);
  logic [3:0] cnt_ff = 4'h0;
  logic [7:0] mem_byte;
  // Stored contents; 30h holds the delivery value
  assign mem_byte = (addr_i == 8'h2B) ? 8'hA5 : (addr_i == 8'h31) ? 8'h11 :
                    (addr_i == 8'h32) ? 8'h22 : (addr_i == 8'h33) ? 8'h33 :
                    (addr_i == 8'h34) ? 8'h44 : 8'h00;
  initial begin
    ack_o = 1'b0;
    data_o = 8'h5A;
  end
  // Data bus shows a toggling pattern when not answering
  always @(posedge sys_clk_i) begin
    ack_o <= 1'b0;
    data_o <= ~data_o;
    if (req_i && !ack_o) begin
      if (cnt_ff >= delay_i) begin
        ack_o <= 1'b1;
        data_o <= mem_byte;
        cnt_ff <= 4'h0;
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end
endmodule

//--- bench/nvpcm_mirror_tb.sv
`timescale 1ns/100ps
module nvpcm_mirror_tb;
  import nvpcm_pkg::*;
  typedef struct packed {
    logic [31:0] key;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wd;
    logic [7:0] rd;
    logic p;
    logic o;
  } nvpcm_row_s;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  nvpcm_req_s req = '0;
  logic [31:0] unlock = 32'h0;
  logic [3:0] dly = 4'h0;
  logic nv_ack, nv_req, rd_valid, prot, wopen, done;
  logic [7:0] nv_data, nv_addr, rd_data;
  logic [7:0] exp_addr [6] = '{8'h2B, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34};
  int n_fail = 0;
  int n_checks = 0;
  int k = 0;
  nvpcm_row_s rows [10] = '{
    '{32'h0, 1'b0, 8'h2B, 8'h00, 8'hA5, 1'b0, 1'b1},
    '{32'h0, 1'b1, 8'h2B, 8'h00, 8'hA5, 1'b0, 1'b1},
    '{32'h0, 1'b0, 8'h30, 8'h00, 8'h00, 1'b0, 1'b1},
    '{32'h0, 1'b0, 8'h31, 8'h00, 8'h00, 1'b0, 1'b1},
    '{32'h0, 1'b0, 8'h40, 8'h00, 8'h00, 1'b0, 1'b1},
    '{32'h0, 1'b1, 8'h30, 8'hFF, 8'hFF, 1'b1, 1'b0},
    '{32'h0, 1'b1, 8'h30, 8'h00, 8'hFF, 1'b1, 1'b0},
    '{32'h44332211, 1'b1, 8'h31, 8'h55, 8'h00, 1'b1, 1'b0},
    '{32'h44332255, 1'b1, 8'h30, 8'hFE, 8'hFE, 1'b0, 1'b1},
    '{32'h0, 1'b1, 8'h34, 8'h77, 8'h00, 1'b0, 1'b1}};

  always #4 sys_clk_i = ~sys_clk_i;

  nvpcm_mirror #(.REFRESH_CYCLES(16)) uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .req_i(req), .unlock_key_i(unlock), .nv_ack_i(nv_ack), .nv_data_i(nv_data),
    .nv_req_o(nv_req), .nv_addr_o(nv_addr), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .protect_on_o(prot), .write_open_o(wopen),
    .load_done_o(done));
  nvpcm_nv_model nvm (.sys_clk_i(sys_clk_i), .req_i(nv_req), .addr_i(nv_addr),
    .delay_i(dly), .ack_o(nv_ack), .data_o(nv_data));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wait_load();
    int i;
    for (i = 0; i < 300 && done !== 1'b1; i++) @(negedge sys_clk_i);
    if (done !== 1'b1) begin
      n_fail++;
      finish_test();
    end
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(negedge sys_clk_i);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk_i);
    chk(rd_valid, 1'b1);
    req = '0;
  endtask

  // Load order seen on the NVM port
  always @(negedge sys_clk_i) begin
    if (nv_ack && nv_req) begin
      chk(nv_addr, exp_addr[k % 6]);
      k++;
    end
  end

  initial begin
    repeat (12) @(negedge sys_clk_i);
    chk({done, prot, wopen, nv_req}, 4'h0);
    rst_i = 1'b0;
    rd_reg(8'h30);
    chk(rd_data, 8'h00);
    wait_load();
    foreach (rows[i]) begin
      @(negedge sys_clk_i);
      unlock = rows[i].key;
      req = '{wr: rows[i].wr, rd: 1'b0, addr: rows[i].addr, wdata: rows[i].wd};
      rd_reg(rows[i].addr);
      chk(rd_data, rows[i].rd);
      chk({prot, wopen}, {rows[i].p, rows[i].o});
    end
    @(negedge sys_clk_i);
    rst_i = 1'b1;
    dly = 4'h5;
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    rd_reg(8'h30);
    chk({rd_data, done}, 9'h000);
    wait_load();
    rd_reg(8'h2B);
    chk(rd_data, 8'hA5);
    chk(k, 12);
    finish_test();
  end
endmodule
